// ---- common/cpu_special_registers_defines.svh ----
// offsets, field positions and constants of the dedicated cpu registers
`ifndef CPU_SPECIAL_REGISTERS_DEFINES_SVH
`define CPU_SPECIAL_REGISTERS_DEFINES_SVH

`define REG_NUM_IP      4'h0
`define REG_NUM_SP      4'h1
`define REG_NUM_FLAGS   4'h2
`define REG_NUM_CONST   4'h3
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_GIE        3
`define FLAG_HALT       4
`define FLAG_LFXT_OFF   5
`define FLAG_DCO_OFF    6
`define FLAG_SUB_OFF    7
`define FLAG_V          8
`define FLAGS_IMPL_MASK 16'h01ff
`define FLAGS_RESET     16'h0000
`define IP_RESET        16'h0000
`define SP_RESET        16'h0000
`define CONST_ZERO      16'h0000
`define CONST_ONE       16'h0001
`define CONST_TWO       16'h0002
`define CONST_FOUR      16'h0004
`define CONST_EIGHT     16'h0008
`define CONST_ONES      16'hffff
`define WORD_STEP       16'h0002
`define EVEN_MASK       16'hfffe

`endif

// ---- common/cpu_special_registers_pkg.sv ----
// types shared by the dedicated cpu register block
package cpu_special_registers_pkg;
  typedef enum logic [1:0] {
    ModeRegister,
    ModeIndexed,
    ModeIndirect,
    ModeAutoInc
  } source_mode_type;

  typedef enum logic [1:0] {
    AluNone,
    AluAdd,
    AluSub
  } alu_class_type;

  typedef enum logic [1:0] {
    StackIdle,
    StackPush,
    StackPop
  } stack_op_type;
endpackage

// ---- rtl/cpu_special_registers.sv ----
// dedicated cpu registers: instruction pointer, stack, flags, constants
//
// Contract
// - pointer advances by two, four or six
// - instruction pointer bit zero always zero
// - any write to pointer redirects execution
// - stack predecrements on push, postincrements on pop
// - stack pointer kept even; software inits it
// - push of stack decrements; pop loads value
// - flags reachable only register mode, word
// - flag bit positions, all reset zero
// - add overflow from like-signed operand rule
// - subtract overflow from unlike-signed operand rule
// - subsystem clock off while its bit set
// - dco bias off unless dco clock used
// - crystal off unless its clock used
// - core halted while halt bit set
// - interrupt enable gates maskable interrupts
// - negative copies bit 15 or 7
// - zero flag set on zero result
// - carry flag follows the carry out
// - register 2 modes: flags, 0, 4, 8
// - register 3 modes: 0, 1, 2, all-ones
// - constants are source-only, no code fetch
// - sixteen registers, 0 to 3 dedicated
`include "cpu_special_registers_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_special_registers (
  // clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    arst_n,
  // source operand request from the decoder
  input  wire logic [3:0]                              srcReg,
  input  wire cpu_special_registers_pkg::source_mode_type source_mode_bits,
  input  wire logic                                    srcByte,
  // register write port
  input  wire logic                                    wrEn,
  input  wire logic [3:0]                              wrReg,
  input  wire logic                                    wrByte,
  input  wire logic [15:0]                             wrData,
  // instruction sequencing
  input  wire logic                                    ipAdvance,
  input  wire logic [1:0]                              ipWords,
  input  wire cpu_special_registers_pkg::stack_op_type stackOp,
  // alu result for flag update
  input  wire cpu_special_registers_pkg::alu_class_type aluClass,
  input  wire logic                                    flagUpdate,
  input  wire logic                                    aluByte,
  input  wire logic [15:0]                             aluOpA,
  input  wire logic [15:0]                             aluOpB,
  input  wire logic [15:0]                             aluResult,
  input  wire logic                                    aluCarry,
  // clock source usage from the clock system
  input  wire logic                                    dcoFeedsClocks,
  input  wire logic                                    lfxtFeedsClocks,
  // maskable interrupt request
  input  wire logic                                    irqPending,
  // outputs
  output logic [15:0]                                  srcData,
  output logic                                         srcIsSpecial,
  output logic                                         constNoFetch,
  output logic [15:0]                                  instruction_pointer,
  output logic [15:0]                                  stack_pointer_reg,
  output logic [15:0]                                  processor_flags,
  output logic                                         subsystem_clock_off,
  output logic                                         dco_bias_off,
  output logic                                         low_freq_crystal_off,
  output logic                                         core_halt,
  output logic                                         irqTake
);
  import cpu_special_registers_pkg::*;

  // decode of source and destination against dedicated registers
  wire srcIsFlagsReg = (srcReg == `REG_NUM_FLAGS);
  wire srcIsConstReg = (srcReg == `REG_NUM_CONST);
  wire srcFlagsRead  = srcIsFlagsReg && (source_mode_bits == ModeRegister)
                       && !srcByte;
  // register 2 modes other than register mode give constants
  wire srcConst      = srcIsConstReg
                       || (srcIsFlagsReg && !srcFlagsRead);
  wire wrIp    = wrEn && (wrReg == `REG_NUM_IP);
  wire wrSp    = wrEn && (wrReg == `REG_NUM_SP);
  // byte writes to the flags or constant register writes are ignored: source-only
  wire wrFlags = wrEn && (wrReg == `REG_NUM_FLAGS) && !wrByte;
  wire [15:0] wrEven = wrData & `EVEN_MASK;

  // constant generator selection
  logic [15:0] constValue;
  always_comb begin
    constValue = `CONST_ZERO;
    if (srcIsConstReg) begin
      case (source_mode_bits)
        ModeRegister: constValue = `CONST_ZERO;
        ModeIndexed:  constValue = `CONST_ONE;
        ModeIndirect: constValue = `CONST_TWO;
        ModeAutoInc:  constValue = `CONST_ONES;
        default:      constValue = `CONST_ZERO;
      endcase
    end else begin
      case (source_mode_bits)
        ModeIndexed:  constValue = `CONST_ZERO;
        ModeIndirect: constValue = `CONST_FOUR;
        ModeAutoInc:  constValue = `CONST_EIGHT;
        default:      constValue = `CONST_ZERO;
      endcase
    end
  end

  // source data mux: byte reads clear the high byte
  logic [15:0] srcWord;
  always_comb begin
    case (srcReg)
      `REG_NUM_IP: srcWord = instruction_pointer;
      `REG_NUM_SP: srcWord = stack_pointer_reg;
      default:     srcWord = srcConst ? constValue : processor_flags;
    endcase
  end
  wire [15:0] next_srcData = srcByte ? {8'h00, srcWord[7:0]} : srcWord;
  wire next_srcIsSpecial = (srcReg[3:2] == 2'b00);

  // instruction pointer: writes branch, otherwise advance by length
  wire [15:0] ipStep = {13'h0, ipWords, 1'b0};
  wire [15:0] next_ip = wrIp ? wrEven
                        : ipAdvance ? ((instruction_pointer + ipStep)
                                       & `EVEN_MASK)
                        : instruction_pointer;

  // stack pointer: a pop of sp itself takes the popped word instead
  wire popIntoSp = (stackOp == StackPop) && wrSp;
  logic [15:0] next_sp;
  always_comb begin
    if (popIntoSp)
      next_sp = wrEven;
    else if (wrSp)
      next_sp = wrEven;
    else if (stackOp == StackPush)
      next_sp = stack_pointer_reg - `WORD_STEP;
    else if (stackOp == StackPop)
      next_sp = stack_pointer_reg + `WORD_STEP;
    else
      next_sp = stack_pointer_reg;
  end

  // alu flag computation; sign bit chosen by operand size
  wire signA = aluByte ? aluOpA[7] : aluOpA[15];
  wire signB = aluByte ? aluOpB[7] : aluOpB[15];
  wire signR = aluByte ? aluResult[7] : aluResult[15];
  wire resZero = aluByte ? (aluResult[7:0] == 8'h00)
                         : (aluResult == 16'h0000);
  wire addOvf = (signA == signB) && (signR != signA);
  // a minus b: opposite signs and result sign differs from a
  wire subOvf = (signA != signB) && (signR != signA);
  wire ovf = (aluClass == AluAdd) ? addOvf
           : (aluClass == AluSub) ? subOvf : 1'b0;

  // flags next value; a direct write wins over the alu update
  logic [15:0] next_flags;
  always_comb begin
    next_flags = processor_flags;
    if (wrFlags) begin
      // reserved bits are read-write too, so the whole word is kept
      next_flags = wrData;
    end else if (flagUpdate) begin
      next_flags[`FLAG_C] = aluCarry;
      next_flags[`FLAG_Z] = resZero;
      next_flags[`FLAG_N] = signR;
      next_flags[`FLAG_V] = ovf;
    end
  end

  // low-power controls; dco and crystal off gated by what the clock system uses
  wire next_subOff  = next_flags[`FLAG_SUB_OFF];
  wire next_dcoOff  = next_flags[`FLAG_DCO_OFF] && !dcoFeedsClocks;
  wire next_lfxtOff = next_flags[`FLAG_LFXT_OFF]
                      && !lfxtFeedsClocks;
  wire next_halt    = next_flags[`FLAG_HALT];
  wire next_irqTake = irqPending && processor_flags[`FLAG_GIE];

  // state registers; low-power outputs are taken from next flag values so they
  // track the stored flags without an extra cycle of lag; irqTake uses the stored GIE bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      instruction_pointer  <= `IP_RESET;
      stack_pointer_reg    <= `SP_RESET;
      processor_flags      <= `FLAGS_RESET;
      subsystem_clock_off  <= 1'b0;
      dco_bias_off         <= 1'b0;
      low_freq_crystal_off <= 1'b0;
      core_halt            <= 1'b0;
      irqTake              <= 1'b0;
      srcData              <= 16'h0000;
      srcIsSpecial         <= 1'b0;
      constNoFetch         <= 1'b0;
    end else begin
      instruction_pointer  <= next_ip;
      stack_pointer_reg    <= next_sp;
      processor_flags      <= next_flags;
      subsystem_clock_off  <= next_subOff;
      dco_bias_off         <= next_dcoOff;
      low_freq_crystal_off <= next_lfxtOff;
      core_halt            <= next_halt;
      irqTake              <= next_irqTake;
      srcData              <= next_srcData;
      srcIsSpecial         <= next_srcIsSpecial;
      constNoFetch         <= srcConst;
    end
  end

  // checks
  a_ip_even: assert property (@(posedge core_clk) disable iff (!arst_n)
    instruction_pointer[0] == 1'b0)
    else $error("instruction pointer odd");

  a_ip_branch: assert property (@(posedge core_clk) disable iff (!arst_n)
    wrIp |=> instruction_pointer == ($past(wrData) & `EVEN_MASK))
    else $error("ip write did not branch");

  a_ip_advance: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ipAdvance && !wrIp) |=> instruction_pointer ==
      (($past(instruction_pointer) + {13'h0, $past(ipWords), 1'b0})
       & `EVEN_MASK))
    else $error("ip advance wrong");

  sequence s_push;
    (stackOp == StackPush) && !wrSp;
  endsequence
  a_sp_push: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_push |=> stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002)
    else $error("push did not predecrement");

  a_sp_popself: assert property (@(posedge core_clk) disable iff (!arst_n)
    popIntoSp |=> stack_pointer_reg == ($past(wrData) & `EVEN_MASK))
    else $error("pop into sp incremented");

  a_sp_even: assert property (@(posedge core_clk) disable iff (!arst_n)
    stack_pointer_reg[0] == 1'b0)
    else $error("stack pointer odd");

  a_flags_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    wrFlags |=> processor_flags == $past(wrData))
    else $error("flag word write lost");

  a_add_ovf: assert property (@(posedge core_clk) disable iff (!arst_n)
    (flagUpdate && !wrFlags && aluClass == AluAdd && !aluByte)
    |=> processor_flags[8] == ($past(aluOpA[15]) == $past(aluOpB[15])
        && $past(aluResult[15]) != $past(aluOpA[15])))
    else $error("add overflow wrong");

  a_zero_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    (flagUpdate && !wrFlags && !aluByte)
    |=> processor_flags[1] == ($past(aluResult) == 16'h0000))
    else $error("zero flag wrong");

  a_const_r3: assert property (@(posedge core_clk) disable iff (!arst_n)
    (srcIsConstReg && source_mode_bits == ModeAutoInc && !srcByte)
    |=> srcData == 16'hffff && constNoFetch)
    else $error("all-ones constant wrong");

  a_halt_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
    core_halt == processor_flags[4])
    else $error("halt does not follow flag");
endmodule

`default_nettype wire

// ---- verification/alu_partner_model.sv ----
// behavioural model of the alu datapath that feeds the flag update
`timescale 1ns/1ps
`default_nettype none

module alu_partner_model (
  // operation from the decoder
  input  wire cpu_special_registers_pkg::alu_class_type aluClass,
  input  wire logic                                     aluByte,
  input  wire logic [15:0]                              aluOpA,
  input  wire logic [15:0]                              aluOpB,
  // result and carry out
  output logic [15:0]                                   aluResult,
  output logic                                          aluCarry
);
  import cpu_special_registers_pkg::*;
  logic        isSub;
  logic [16:0] wordSum;
  logic [8:0]  byteSum;
  // subtract as a plus inverted b plus one, so carry means no borrow
  assign isSub     = (aluClass == AluSub);
  assign wordSum   = {1'b0, aluOpA} + {1'b0, isSub ? ~aluOpB : aluOpB} + 17'(isSub);
  assign byteSum   = {1'b0, aluOpA[7:0]} + {1'b0, isSub ? ~aluOpB[7:0] : aluOpB[7:0]}
                     + 9'(isSub);
  assign aluResult = aluByte ? {8'h00, byteSum[7:0]} : wordSum[15:0];
  assign aluCarry  = aluByte ? byteSum[8] : wordSum[16];
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the dedicated cpu registers
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cpu_special_registers_pkg::*;
  `define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    fail_count++; $display("FAIL %s exp %h got %h", nm, ex, got); end end
  typedef struct {alu_class_type c; logic b; logic [15:0] a, o; logic [3:0] f;} row_type;
  logic core_clk, arst_n, srcByte, wrEn, wrByte, ipAdvance, flagUpdate, aluByte;
  logic aluCarry, dcoFeedsClocks, lfxtFeedsClocks, irqPending, srcIsSpecial;
  logic constNoFetch, subOff, dcoOff, xtalOff, halt, irqTake;
  logic [3:0] srcReg, wrReg;
  logic [1:0] ipWords;
  logic [15:0] wrData, aluOpA, aluOpB, aluResult, srcData, ip, sp, flags;
  source_mode_type srcMode;
  stack_op_type stackOp;
  alu_class_type aluClass;
  int fail_count = 0;
  int n_tests = 0;
  // flag rows: class, byte, a, b, expected {overflow, negative, zero, carry}
  row_type rows[7] = '{'{AluAdd, 1'b0, 16'h7fff, 16'h0001, 4'hc},
    '{AluAdd, 1'b0, 16'hffff, 16'h0001, 4'h3}, '{AluAdd, 1'b1, 16'h0080, 16'h0080, 4'hb},
    '{AluSub, 1'b0, 16'h8000, 16'h0001, 4'h9}, '{AluSub, 1'b1, 16'h0005, 16'h0005, 4'h3},
    '{AluSub, 1'b0, 16'h0001, 16'h0002, 4'h4}, '{AluSub, 1'b0, 16'h7fff, 16'hffff, 4'hc}};
  logic [15:0] cst[8] = '{16'hff01, 16'h0000, 16'h0004, 16'h0008,
                          16'h0000, 16'h0001, 16'h0002, 16'hffff};

  cpu_special_registers dut (.core_clk(core_clk), .arst_n(arst_n), .srcReg(srcReg),
    .source_mode_bits(srcMode), .srcByte(srcByte), .wrEn(wrEn), .wrReg(wrReg),
    .wrByte(wrByte), .wrData(wrData), .ipAdvance(ipAdvance), .ipWords(ipWords),
    .stackOp(stackOp), .aluClass(aluClass), .flagUpdate(flagUpdate),
    .aluByte(aluByte), .aluOpA(aluOpA), .aluOpB(aluOpB), .aluResult(aluResult),
    .aluCarry(aluCarry), .dcoFeedsClocks(dcoFeedsClocks),
    .lfxtFeedsClocks(lfxtFeedsClocks), .irqPending(irqPending), .srcData(srcData),
    .srcIsSpecial(srcIsSpecial), .constNoFetch(constNoFetch),
    .instruction_pointer(ip), .stack_pointer_reg(sp), .processor_flags(flags),
    .subsystem_clock_off(subOff), .dco_bias_off(dcoOff),
    .low_freq_crystal_off(xtalOff), .core_halt(halt), .irqTake(irqTake));
  alu_partner_model alu (.aluClass(aluClass), .aluByte(aluByte), .aluOpA(aluOpA),
    .aluOpB(aluOpB), .aluResult(aluResult), .aluCarry(aluCarry));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // one edge that takes the request, pulses dropped so each acts once
  task automatic go;
    @(posedge core_clk);
    wrEn <= 1'b0; ipAdvance <= 1'b0; stackOp <= StackIdle; flagUpdate <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] r, input logic [15:0] d, input logic b);
    @(posedge core_clk);
    wrEn <= 1'b1; wrReg <= r; wrData <= d; wrByte <= b;
    go;
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the sequence needs well under a hundred cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop;
  end

  // main sequence
  initial begin
    {arst_n, srcByte, wrEn, wrByte, ipAdvance, flagUpdate, aluByte} = '0;
    {dcoFeedsClocks, lfxtFeedsClocks, irqPending, ipWords} = '0;
    {srcReg, wrReg, wrData, aluOpA, aluOpB} = '0;
    srcMode = ModeRegister; stackOp = StackIdle; aluClass = AluNone;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 `CHK("flags", 16'h0000, flags)
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      aluClass <= rows[i].c; aluByte <= rows[i].b; aluOpA <= rows[i].a;
      aluOpB <= rows[i].o; flagUpdate <= 1'b1;
      go;
      `CHK("vnzc", rows[i].f, {flags[8], flags[2:0]})
    end
    // pointer: odd write, advance by three words, write beating advance
    wr(4'h0, 16'h1235, 1'b0); `CHK("ip", 16'h1234, ip)
    @(posedge core_clk); ipAdvance <= 1'b1; ipWords <= 2'd3; go;
    `CHK("ip", 16'h123a, ip)
    @(posedge core_clk); ipAdvance <= 1'b1; ipWords <= 2'd1;
    wrEn <= 1'b1; wrReg <= 4'h0; wrData <= 16'h0800; go;
    `CHK("ip", 16'h0800, ip)
    // stack: even on write, push, pop, pop of the stack pointer itself
    wr(4'h1, 16'h0401, 1'b0); `CHK("sp", 16'h0400, sp)
    @(posedge core_clk); stackOp <= StackPush; go; `CHK("sp", 16'h03fe, sp)
    @(posedge core_clk); stackOp <= StackPop; go; `CHK("sp", 16'h0400, sp)
    @(posedge core_clk); stackOp <= StackPop;
    wrEn <= 1'b1; wrReg <= 4'h1; wrData <= 16'h0300; go;
    `CHK("sp", 16'h0300, sp)
    // low-power bits with no clock using the sources, then with them used
    wr(4'h2, 16'h00f8, 1'b0);
    `CHK("halt", 1'b1, halt)
    `CHK("subOff", 1'b1, subOff)
    `CHK("dcoOff", 1'b1, dcoOff)
    `CHK("xtalOff", 1'b1, xtalOff)
    @(posedge core_clk); dcoFeedsClocks <= 1'b1; lfxtFeedsClocks <= 1'b1; go; go;
    `CHK("dcoOff", 1'b0, dcoOff)
    `CHK("xtalOff", 1'b0, xtalOff)
    @(posedge core_clk); irqPending <= 1'b1; go; go;
    `CHK("irqTake", 1'b1, irqTake)
    wr(4'h2, 16'h0000, 1'b0); go;
    `CHK("irqTake", 1'b0, irqTake)
    wr(4'h2, 16'h00ff, 1'b1); `CHK("flags", 16'h0000, flags)
    wr(4'h2, 16'hff01, 1'b0); `CHK("flags", 16'hff01, flags)
    wr(4'h3, 16'h1234, 1'b0);
    // every source mode of registers 2 and 3
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      srcReg <= {3'b001, i[2]}; srcMode <= source_mode_type'(i[1:0]);
      go;
      `CHK("src", cst[i], srcData)
      `CHK("noFetch", (i != 0), constNoFetch)
      `CHK("special", 1'b1, srcIsSpecial)
    end
    report_and_stop;
  end
  `undef CHK
endmodule

`default_nettype wire
